// *** rtl/gcd_decoder.sv ***
// Graphics command decoder: takes host command and parameter words, decodes them,
// latches drawing fields and pointers, and counts out each command's execution cycles.
// Assumes the host polls the busy bit before writing and reads results one word at a time.
// Operation
// RULE_01: Origin opcode takes two parameters, eight cycles
// RULE_02: Host sets origin before any drawing command
// RULE_03: Origin sets drawing base and screen select
// RULE_04: Origin words split into screen, address, pixel
// RULE_05: Origin loads drawing pointer, clears current position
// RULE_06: Parameter write stores one word, six cycles
// RULE_07: Parameter read has no parameters, six cycles
// RULE_08: Parameter read result goes to read port
// RULE_09: Pattern write takes index, count, n words
// RULE_10: Pattern read takes count, 4n+10 cycles
// RULE_11: DMA commands take horizontal and vertical counts
// RULE_12: Word read 12 cycles, write/change eight
// RULE_13: Area fills take data and two counts
// RULE_14: Copies carry direction bits, five words
// RULE_15: Leading one marks drawing command with modes
// RULE_16: Multi-segment commands take count, n pairs
// RULE_17: Moves take two coordinates, relative 56 cycles
// RULE_18: Pattern size high byte vertical, low horizontal
// RULE_19: Pixel copies take source and extent, five words
// RULE_20: Paint edge flag selects stop condition
// RULE_21: Arc direction flag one means clockwise
// RULE_22: Dot factor four or six by logic mode
// RULE_23: All parameters consumed before next command
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module gcd_decoder (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [15:0] reg_rdata_o,
	output logic busy_o,
	output gcd_pkg::gcd_mode_t draw_mode_o,
	output logic [2:0] dot_factor_o,
	output logic fill_stop_equal_o,
	output logic arc_clockwise_o,
	output gcd_pkg::gcd_ptr_t drawing_pointer_o,
	output logic [15:0] cur_x_o,
	output logic [15:0] cur_y_o,
	output logic [15:0] horizontal_word_count_o,
	output logic [15:0] vertical_line_count_o,
	output logic [1:0] mask_mode_o,
	output logic source_dir_o,
	output logic [2:0] scan_direction_code_o,
	output logic [15:0] source_addr_high_o,
	output logic [15:0] source_addr_low_o,
	output logic [15:0] fill_data_o,
	output logic [7:0] pattern_height_o,
	output logic [7:0] pattern_width_o
);
	import gcd_pkg::*;

	// All block state in one struct
	typedef struct packed {
		gcd_phase_t phase;
		logic busy;
		logic [15:0] cmd;
		logic [15:0] idx;
		logic [16:0] left;
		logic [15:0] cnt;
		logic [15:0] hold;
		logic [17:0] timer;
		logic [15:0] last_cyc;
		logic [15:0] rd_left;
		logic [3:0] ptr;
		logic [15:0] rd_word;
		logic rd_full;
		logic origin_set;
		logic [15:0] rdata;
		gcd_mode_t mode;
		logic [2:0] factor;
		logic stop_eq;
		logic arc_cw;
		gcd_ptr_t dp;
		logic [15:0] cx;
		logic [15:0] cy;
		logic [15:0] ax;
		logic [15:0] ay;
		logic [1:0] mm;
		logic sdir;
		logic [2:0] scan_direction_code;
		logic [15:0] source_addr_high;
		logic [15:0] source_addr_low;
		logic [15:0] fdata;
		logic [15:0] psize;
		logic [31:0][15:0] preg;
		logic [15:0][15:0] pat;
	} gcd_state_t;

	gcd_state_t s;
	gcd_state_t next_s;

	// Fixed word count of a command, including the command word itself and any count word
	function automatic logic [2:0] words_of(input logic [5:0] op);
		logic [2:0] w;
		w = 3'h1;
		casez (op)
			OP_ORIGIN: w = 3'h3; // RULE_01
			OP_PREG_WR: w = 3'h2; // RULE_06
			OP_PREG_RD: w = 3'h1; // RULE_07
			OP_PAT_WR: w = 3'h2; // RULE_09
			OP_PAT_RD: w = 3'h2; // RULE_10
			6'b0010??: w = (op[1:0] == 2'b00) ? 3'h1 : 3'h3; // RULE_11
			OP_WORD_RD: w = 3'h1; // RULE_12
			6'b01001?: w = 3'h2; // RULE_12
			6'b01011?: w = 3'h4; // RULE_13
			6'b011???: w = 3'h5; // RULE_14
			6'b1000??: w = 3'h3; // RULE_17
			6'b10010?: w = 3'h3;
			6'b10011?: w = 3'h2; // RULE_16
			6'b10100?: w = 3'h2; // RULE_16
			6'b101010: w = 3'h2;
			6'b101011: w = 3'h4;
			6'b10110?: w = 3'h5;
			6'b10111?: w = 3'h7;
			6'b11000?: w = 3'h3;
			6'b1101??: w = 3'h2; // RULE_18
			6'b111???: w = 3'h5; // RULE_19
			default: w = 3'h1;
		endcase
		return w;
	endfunction : words_of

	// Commands whose first parameter is a count that lengthens them
	function automatic logic is_var(input logic [5:0] op);
		return (op == OP_PAT_WR) || (op[5:1] == 5'b10011) || (op[5:1] == 5'b10100);
	endfunction : is_var

	// Two-coordinate commands that leave the current position at their end point
	function automatic logic is_xy(input logic [5:0] op);
		return (op[5:2] == 4'b1000) || (op[5:1] == 5'b10010) || (op[5:1] == 5'b11000);
	endfunction : is_xy

	// Cycle count of a command; data-dependent drawing time belongs to the drawing datapath
	function automatic logic [17:0] cycles_of(input logic [5:0] op, input logic [15:0] n);
		logic [17:0] c;
		c = CYC_OTHER;
		case (op)
			OP_ORIGIN: c = CYC_ORIGIN; // RULE_01
			OP_PREG_WR: c = CYC_PREG; // RULE_06
			OP_PREG_RD: c = CYC_PREG; // RULE_07
			OP_PAT_WR: c = {n, 2'b00} + CYC_PAT_WR; // RULE_09
			OP_PAT_RD: c = {n, 2'b00} + CYC_PAT_RD; // RULE_10
			OP_WORD_RD: c = CYC_WORD_RD; // RULE_12
			OP_WORD_WR: c = CYC_WORD_WR; // RULE_12
			OP_WORD_CHG: c = CYC_WORD_WR; // RULE_12
			OP_REL_MOVE: c = CYC_REL_MOVE; // RULE_17
			OP_DOT: c = CYC_DOT;
			default: c = CYC_OTHER;
		endcase
		return c;
	endfunction : cycles_of

	logic [5:0] op;
	logic [15:0] w;
	logic cmd_wr;
	logic rd_pop;

	assign op = s.cmd[15:10];
	assign w = reg_wdata_i;
	assign cmd_wr = reg_we_i && (reg_addr_i == REG_CMD);
	assign rd_pop = reg_re_i && (reg_addr_i == REG_RDATA);

	// Next-state logic: register reads, command decode, parameter collection, execution
	always_comb begin
		logic done;
		logic [5:0] wop;
		logic [17:0] cyc;
		done = 1'b0;
		wop = w[15:10];
		cyc = CYC_OTHER;
		next_s = s;

		// Register read port; data stands in the following cycle only
		next_s.rdata = 16'h0000;
		if (reg_re_i) begin
			case (reg_addr_i)
				REG_RDATA: next_s.rdata = s.rd_word;
				REG_STATUS: next_s.rdata = {13'h0, s.origin_set, s.rd_full, s.phase != PH_IDLE};
				REG_CYCLES: next_s.rdata = s.last_cyc;
				REG_DP_LOW: next_s.rdata = s.dp.addr[15:0];
				REG_DP_HIGH: next_s.rdata = {s.dp.screen, 6'h00, s.dp.pix, s.dp.addr[19:16]};
				REG_CUR_X: next_s.rdata = s.cx;
				REG_CUR_Y: next_s.rdata = s.cy;
				default: next_s.rdata = 16'h0000;
			endcase
		end
		// Reading the result word empties the holding register
		if (rd_pop) begin
			next_s.rd_full = 1'b0;
		end

		case (s.phase)
			PH_IDLE: begin
				if (cmd_wr) begin
					next_s.cmd = w;
					next_s.idx = 16'h0001;
					next_s.ptr = w[3:0];
					// Drawing command word carries the mode fields
					if (w[15]) begin
						next_s.mode.area = w[7:5]; // RULE_15
						next_s.mode.col = w[4:3]; // RULE_15
						next_s.mode.pixel_logic_mode = w[2:0]; // RULE_15
						next_s.factor = w[2] ? DOT_FACTOR_HIGH : DOT_FACTOR_LOW; // RULE_22
					end
					if (wop == OP_PAINT) begin
						next_s.stop_eq = ~w[8]; // RULE_20
					end
					if (wop[5:2] == 4'b1011) begin
						next_s.arc_cw = w[8]; // RULE_21
					end
					// Copy families carry source direction and scan code
					if (w[14:13] == 2'b11) begin
						next_s.sdir = w[11]; // RULE_14
						next_s.scan_direction_code = w[10:8]; // RULE_14
					end
					if ((wop == OP_DMA_CHG) || (wop == OP_WORD_CHG) || (wop == OP_AREA_MFILL)) begin
						next_s.mm = w[1:0]; // RULE_11
					end
					if (words_of(wop) == 3'h1) begin
						done = 1'b1;
					end else begin
						next_s.phase = PH_PARAM;
						next_s.left = is_var(wop) ? 17'h00001 : {14'h0, words_of(wop) - 3'h1};
					end
				end
			end
			PH_PARAM: begin
				// Words are taken strictly in order until the command is complete
				if (cmd_wr) begin
					next_s.idx = s.idx + 16'h0001; // RULE_23
					next_s.left = s.left - 17'h00001; // RULE_23
					casez (op)
						OP_ORIGIN: begin
							if (s.idx == 16'h0001) begin
								next_s.hold = w;
							end else begin
								next_s.dp.screen = s.hold[15:14]; // RULE_04
								next_s.dp.pix = s.hold[7:4]; // RULE_04
								next_s.dp.addr = {s.hold[3:0], w}; // RULE_04
								next_s.cx = 16'h0000; // RULE_05
								next_s.cy = 16'h0000; // RULE_05
								next_s.origin_set = 1'b1; // RULE_03
							end
						end
						OP_PREG_WR: next_s.preg[s.cmd[4:0]] = w; // RULE_06
						OP_PAT_WR: begin
							if (s.idx == 16'h0001) begin
								next_s.cnt = w;
								next_s.left = {1'b0, w}; // RULE_09
							end else begin
								next_s.pat[s.ptr] = w; // RULE_09
								next_s.ptr = s.ptr + 4'h1;
							end
						end
						OP_PAT_RD: begin
							next_s.cnt = w; // RULE_10
							next_s.rd_left = w;
						end
						6'b0010??: begin
							if (s.idx == 16'h0001) begin
								next_s.ax = w; // RULE_11
							end else begin
								next_s.ay = w; // RULE_11
							end
						end
						6'b01001?: next_s.fdata = w; // RULE_12
						6'b01011?: begin
							case (s.idx[1:0])
								2'h1: next_s.fdata = w; // RULE_13
								2'h2: next_s.ax = w; // RULE_13
								default: next_s.ay = w; // RULE_13
							endcase
						end
						6'b?11???: begin
							case (s.idx[2:0])
								3'h1: next_s.source_addr_high = w; // RULE_19
								3'h2: next_s.source_addr_low = w; // RULE_19
								3'h3: next_s.ax = w; // RULE_14
								default: next_s.ay = w; // RULE_14
							endcase
						end
						6'b1101??: next_s.psize = w; // RULE_18
						6'b10011?, 6'b10100?: begin
							if (s.idx == 16'h0001) begin
								next_s.left = {w, 1'b0}; // RULE_16
							end
						end
						default: begin
							// Coordinates of moves, lines, rectangles
							if (is_xy(op)) begin
								if (s.idx == 16'h0001) begin
									next_s.hold = w;
								end else if (op[0]) begin
									next_s.cx = s.cx + s.hold; // RULE_17
									next_s.cy = s.cy + w; // RULE_17
								end else begin
									next_s.cx = s.hold; // RULE_17
									next_s.cy = w; // RULE_17
								end
							end
						end
					endcase
					// Last word, or a count of zero, ends collection
					if ((next_s.left == 17'h00000) || (s.left == 17'h00001 && !is_var(op))) begin
						done = 1'b1;
					end
				end
			end
			PH_EXEC: begin
				// Pattern words go out one at a time as the host takes them
				if ((s.rd_left != 16'h0000) && (!s.rd_full || rd_pop)) begin
					next_s.rd_word = s.pat[s.ptr]; // RULE_10
					next_s.rd_full = 1'b1;
					next_s.ptr = s.ptr + 4'h1;
					next_s.rd_left = s.rd_left - 16'h0001;
				end
				if (s.timer != 18'h00000) begin
					next_s.timer = s.timer - 18'h00001;
				end else if (s.rd_left == 16'h0000) begin
					next_s.phase = PH_IDLE;
				end
			end
			default: next_s.phase = PH_IDLE;
		endcase

		// Command complete: start the execution count
		if (done) begin
			cyc = cycles_of(next_s.cmd[15:10], next_s.cnt);
			next_s.phase = PH_EXEC;
			next_s.left = 17'h00000;
			next_s.timer = cyc - 18'h00001;
			next_s.last_cyc = cyc[15:0];
			if (next_s.cmd[15:10] == OP_PREG_RD) begin
				next_s.rd_word = s.preg[next_s.cmd[4:0]]; // RULE_08
				next_s.rd_full = 1'b1; // RULE_08
			end
		end
		// Busy kept as its own flop so the pin is not decoded from the phase
		next_s.busy = (next_s.phase != PH_IDLE);
	end

	// State register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign reg_rdata_o = s.rdata;
	assign busy_o = s.busy;
	assign draw_mode_o = s.mode;
	assign dot_factor_o = s.factor;
	assign fill_stop_equal_o = s.stop_eq;
	assign arc_clockwise_o = s.arc_cw;
	assign drawing_pointer_o = s.dp;
	assign cur_x_o = s.cx;
	assign cur_y_o = s.cy;
	assign horizontal_word_count_o = s.ax;
	assign vertical_line_count_o = s.ay;
	assign mask_mode_o = s.mm;
	assign source_dir_o = s.sdir;
	assign scan_direction_code_o = s.scan_direction_code;
	assign source_addr_high_o = s.source_addr_high;
	assign source_addr_low_o = s.source_addr_low;
	assign fill_data_o = s.fdata;
	assign pattern_height_o = s.psize[15:8];
	assign pattern_width_o = s.psize[7:0];
endmodule : gcd_decoder

// *** rtl/gcd_pkg.sv ***
// Package for the graphics command decoder: opcodes, register map, cycle counts, carrier types.
// Assumes one 250 MHz clock; host words are 16 bits wide.
package gcd_pkg;
	// Register word offsets on the plain register port
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_RDATA = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_CYCLES = 4'h3;
	localparam logic [3:0] REG_DP_LOW = 4'h4;
	localparam logic [3:0] REG_DP_HIGH = 4'h5;
	localparam logic [3:0] REG_CUR_X = 4'h6;
	localparam logic [3:0] REG_CUR_Y = 4'h7;
	// Status bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_RD_FULL = 1;
	localparam int ST_ORIGIN = 2;
	// Upper six opcode bits
	localparam logic [5:0] OP_ORIGIN = 6'h01;
	localparam logic [5:0] OP_PREG_WR = 6'h02;
	localparam logic [5:0] OP_PREG_RD = 6'h03;
	localparam logic [5:0] OP_PAT_WR = 6'h06;
	localparam logic [5:0] OP_PAT_RD = 6'h07;
	localparam logic [5:0] OP_DMA_RD = 6'h09;
	localparam logic [5:0] OP_DMA_WR = 6'h0A;
	localparam logic [5:0] OP_DMA_CHG = 6'h0B;
	localparam logic [5:0] OP_WORD_RD = 6'h11;
	localparam logic [5:0] OP_WORD_WR = 6'h12;
	localparam logic [5:0] OP_WORD_CHG = 6'h13;
	localparam logic [5:0] OP_AREA_FILL = 6'h16;
	localparam logic [5:0] OP_AREA_MFILL = 6'h17;
	localparam logic [5:0] OP_ABS_MOVE = 6'h20;
	localparam logic [5:0] OP_REL_MOVE = 6'h21;
	localparam logic [5:0] OP_PAINT = 6'h32;
	localparam logic [5:0] OP_DOT = 6'h33;
	// Execution cycle counts; the pattern counts are bases added to four cycles per word
	localparam logic [17:0] CYC_ORIGIN = 18'h00008;
	localparam logic [17:0] CYC_PREG = 18'h00006;
	localparam logic [17:0] CYC_PAT_WR = 18'h00008;
	localparam logic [17:0] CYC_PAT_RD = 18'h0000A;
	localparam logic [17:0] CYC_WORD_RD = 18'h0000C;
	localparam logic [17:0] CYC_WORD_WR = 18'h00008;
	localparam logic [17:0] CYC_REL_MOVE = 18'h00038;
	localparam logic [17:0] CYC_DOT = 18'h00008;
	localparam logic [17:0] CYC_OTHER = 18'h00001;
	// Per-dot cycle factors by pixel logic mode
	localparam logic [2:0] DOT_FACTOR_LOW = 3'h4;
	localparam logic [2:0] DOT_FACTOR_HIGH = 3'h6;
	// Drawing mode fields carried by a drawing command word
	typedef struct packed {
		logic [2:0] area;
		logic [1:0] col;
		logic [2:0] pixel_logic_mode;
	} gcd_mode_t;
	// Drawing pointer: screen, 20 bit word address, pixel bit field
	typedef struct packed {
		logic [1:0] screen;
		logic [3:0] pix;
		logic [19:0] addr;
	} gcd_ptr_t;
	typedef enum logic [1:0] {PH_IDLE, PH_PARAM, PH_EXEC} gcd_phase_t;
endpackage : gcd_pkg

// *** tb/gcd_host_model.sv ***
// Host model: writes command words and reads results on the decoder's register port.
// Assumes one caller at a time; every signal changes just after a rising edge.
`timescale 1ns/10ps
module gcd_host_model (
	input wire logic clk_i,
	input wire logic busy_i,
	input wire logic [15:0] rdata_i,
	output logic [3:0] addr_o,
	output logic [15:0] wdata_o,
	output logic we_o,
	output logic re_o
);
	import gcd_pkg::*;
	initial begin
		addr_o = 4'h0;
		wdata_o = 16'h0000;
		we_o = 1'b0;
		re_o = 1'b0;
	end
	// One strobe, held to the taking edge; data is inverted once released
	task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		we_o <= w;
		re_o <= !w;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		we_o <= 1'b0;
		re_o <= 1'b0;
		wdata_o <= ~d;
	endtask : bus
	task wr(input logic [15:0] d);
		bus(1'b1, REG_CMD, d);
	endtask : wr
	task rd(input logic [3:0] a, output logic [15:0] v);
		bus(1'b0, a, 16'h0000);
		@(negedge clk_i);
		v = rdata_i;
	endtask : rd
	// Counts the cycles busy stands; the next command waits for idle
	task settle(output int n);
		n = 0;
		repeat (300) begin
			@(negedge clk_i);
			if (busy_i !== 1'b1) break;
			n++;
		end
	endtask : settle
	// Command word first, then its parameters in order
	task cmd(input logic [15:0] q[$], output int n);
		foreach (q[i]) wr(q[i]);
		settle(n);
	endtask : cmd
	// Polls for a held result word before taking it
	task pop(output logic [15:0] v);
		repeat (100) begin
			rd(REG_STATUS, v);
			if (v[ST_RD_FULL] === 1'b1) break;
		end
		rd(REG_RDATA, v);
	endtask : pop
endmodule : gcd_host_model

// *** tb/gcd_decoder_properties.sv ***
// Port checker for the command decoder, bound into every decoder instance.
// Assumes one clock and an asynchronous active low reset.
`timescale 1ns/10ps
module gcd_decoder_properties (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic busy_o,
	input wire gcd_pkg::gcd_mode_t draw_mode_o,
	input wire logic [2:0] dot_factor_o,
	input wire logic fill_stop_equal_o,
	input wire gcd_pkg::gcd_ptr_t drawing_pointer_o,
	input wire logic [15:0] cur_x_o,
	input wire logic [15:0] cur_y_o
);
	import gcd_pkg::*;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	// A command word taken while idle; writes during execution do not count
	logic take;
	logic [5:0] op;
	assign take = reg_we_i && reg_addr_i == REG_CMD && !busy_o;
	assign op = reg_wdata_i[15:10];
	chk_rdata_one_cycle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 16'h0000)
		else $error("read data outside its cycle");
	chk_busy_on_take: assert property (take |=> busy_o)
		else $error("command word did not start busy");
	chk_param_read_time: assert property (take && op == OP_PREG_RD |=> busy_o [*6] ##1 !busy_o)
		else $error("parameter read time wrong");
	chk_word_read_time: assert property (take && op == OP_WORD_RD |-> ##12 busy_o ##1 !busy_o)
		else $error("word read time wrong");
	chk_factor_by_mode: assert property (draw_mode_o != 8'h00 |->
		dot_factor_o == (draw_mode_o.pixel_logic_mode[2] ? DOT_FACTOR_HIGH : DOT_FACTOR_LOW))
		else $error("dot factor wrong");
	chk_paint_edge_flag: assert property (take && op == OP_PAINT |=>
		fill_stop_equal_o == !$past(reg_wdata_i[8]))
		else $error("paint edge flag wrong");
	chk_origin_clears: assert property ($changed(drawing_pointer_o) |->
		cur_x_o == 16'h0000 && cur_y_o == 16'h0000)
		else $error("origin left position set");
	chk_pointer_idle: assert property (!busy_o |=> $stable(drawing_pointer_o))
		else $error("pointer moved while idle");
	chk_mode_busy: assert property ($changed(draw_mode_o) |-> busy_o)
		else $error("mode changed outside a command");
	cover property (take && op == OP_ORIGIN);
	cover property (take && op == OP_PAINT);
	cover property ($fell(busy_o));
endmodule : gcd_decoder_properties
bind gcd_decoder gcd_decoder_properties u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
	.busy_o(busy_o), .draw_mode_o(draw_mode_o), .dot_factor_o(dot_factor_o),
	.fill_stop_equal_o(fill_stop_equal_o), .drawing_pointer_o(drawing_pointer_o),
	.cur_x_o(cur_x_o), .cur_y_o(cur_y_o));

// *** tb/testbench.sv ***
// Bench for the command decoder: the host model sends commands, the bench checks ports and timing.
// Assumes the package, the host model and the checker are compiled first.
`timescale 1ns/10ps
module testbench;
	import gcd_pkg::*;
	`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end
	int checked = 0;
	int mismatches = 0;
	int n;
	logic clk_i, resetn_i, we, re, busy, fse, acw, sdir;
	logic [3:0] addr;
	logic [2:0] dfac, sdc;
	logic [1:0] mm;
	logic [7:0] ph, pw;
	logic [15:0] wd, rd, v, cx, cy, hwc, vlc, source_addr_high, source_addr_low, fd;
	gcd_mode_t mode;
	gcd_ptr_t dp;
	gcd_decoder u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rd), .busy_o(busy), .draw_mode_o(mode),
		.dot_factor_o(dfac), .fill_stop_equal_o(fse), .arc_clockwise_o(acw), .drawing_pointer_o(dp),
		.cur_x_o(cx), .cur_y_o(cy), .horizontal_word_count_o(hwc), .vertical_line_count_o(vlc),
		.mask_mode_o(mm), .source_dir_o(sdir), .scan_direction_code_o(sdc), .source_addr_high_o(source_addr_high),
		.source_addr_low_o(source_addr_low), .fill_data_o(fd), .pattern_height_o(ph), .pattern_width_o(pw));
	gcd_host_model u_host (.clk_i(clk_i), .busy_i(busy), .rdata_i(rd), .addr_o(addr), .wdata_o(wd),
		.we_o(we), .re_o(re));
	// Busy stands exactly the execution count after the last word is taken
	task run(input logic [15:0] q[$], input int c);
		u_host.cmd(q, n);
		`CHK(n, c)
	endtask : run
	task rchk(input logic [3:0] a, input logic [15:0] e);
		u_host.rd(a, v);
		`CHK(v, e)
	endtask : rchk
	task results();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// Whole run needs well under ten microseconds
	initial begin
		#50000;
		mismatches++;
		results();
	end
	initial begin
		resetn_i = 1'b0;
		repeat (8) @(posedge clk_i);
		resetn_i <= 1'b1;
		rchk(REG_STATUS, 16'h0000);
		// Origin goes out before any drawing so addresses have a base
		run('{16'h0400, 16'h8035, 16'h1234}, 8);
		`CHK(dp, 26'h2351234)
		rchk(REG_DP_HIGH, 16'h8035);
		rchk(REG_STATUS, 16'h0004);
		run('{16'h8000, 16'h0010, 16'h0020}, 1);
		run('{16'h8400, 16'h0001, 16'h0002}, 56);
		rchk(REG_CUR_X, 16'h0011);
		`CHK(cy, 16'h0022)
		run('{16'h0400, 16'h0000, 16'h0025}, 8);
		`CHK({dp, cx, cy}, {26'h25, 32'h0})
		run('{16'h0801, 16'h1111}, 6);
		run('{16'h0C01}, 6);
		u_host.pop(v);
		`CHK(v, 16'h1111)
		// Pattern index starts at the top word and wraps
		run('{16'h180F, 16'h0002, 16'h2314, 16'h5713}, 16);
		u_host.wr(16'h1C0F);
		u_host.wr(16'h0002);
		u_host.pop(v);
		`CHK(v, 16'h2314)
		u_host.pop(v);
		`CHK(v, 16'h5713)
		u_host.settle(n);
		run('{16'h4400}, 12);
		run('{16'h4800, 16'hAAAA}, 8);
		run('{16'h4C02, 16'h5555}, 8);
		`CHK(mm, 2'h2)
		run('{16'h2400, 16'h0003, 16'h0004}, 1);
		run('{16'h2C01, 16'h0005, 16'h0006}, 1);
		`CHK({mm, hwc, vlc}, {2'h1, 32'h00050006})
		run('{16'h5800, 16'hBEEF, 16'h0007, 16'h0008}, 1);
		`CHK({fd, hwc, vlc}, 48'hBEEF00070008)
		run('{16'h5C03, 16'h1234, 16'h0007, 16'h0008}, 1);
		`CHK(mm, 2'h3)
		run('{16'h6D00, 16'h0001, 16'h0002, 16'h0009, 16'h000A}, 1);
		`CHK({sdir, sdc, source_addr_high, source_addr_low}, {1'b1, 3'h5, 32'h00010002})
		run('{16'hF2A5, 16'h0001, 16'h0002, 16'h0003, 16'h0004}, 1);
		`CHK({mode, sdir, sdc}, {8'hA5, 1'b0, 3'h2})
		run('{16'hD0AD, 16'h0A05}, 1);
		`CHK({ph, pw, dfac}, {16'h0A05, 3'h6})
		run('{16'h880B, 16'h0003, 16'h0004}, 1);
		`CHK({mode, dfac}, {8'h0B, 3'h4})
		run('{16'h9800, 16'h0002, 16'h0001, 16'h0002, 16'h0003, 16'h0004}, 1);
		// Closed outline with one pair, then a dot with a high logic mode
		run('{16'hA001, 16'h0001, 16'h0007, 16'h0008}, 1);
		`CHK(dfac, 3'h4)
		run('{16'hCC1C}, 8);
		`CHK({mode, dfac}, {8'h1C, 3'h6})
		run('{16'hC900}, 1);
		`CHK(fse, 1'b0)
		run('{16'hC800}, 1);
		`CHK(fse, 1'b1)
		run('{16'hB100, 16'h0001, 16'h0002, 16'h0003, 16'h0004}, 1);
		`CHK(acw, 1'b1)
		run('{16'hB000, 16'h0001, 16'h0002, 16'h0003, 16'h0004}, 1);
		`CHK(acw, 1'b0)
		// An origin word sent during execution must be dropped, not swallow the move
		u_host.wr(16'h4400);
		u_host.wr(16'h0400);
		u_host.settle(n);
		run('{16'h8000, 16'h0005, 16'h0006}, 1);
		`CHK({dp, cx, cy}, {26'h25, 32'h00050006})
		rchk(4'hC, 16'h0000);
		results();
	end
endmodule : testbench
